/* logic/rx_user_pkg.sv */
// Purpose: Shared constants for the receive user data interface
// Assumes: APB register access, 32-bit data
// Notes: Register byte offsets are word aligned
package rx_user_pkg;
	localparam int WORD_BITS = 64;
	localparam int DEF_WORDS = 8;
	localparam int CHAN_BITS = 8;
	localparam int ADDR_BITS = 12;
	// ------------------------------------------------
	// Register map
	// ------------------------------------------------
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] PKT_CNT_OFS = 12'h004;
	localparam logic [11:0] ERR_CNT_OFS = 12'h008;
	localparam int CTRL_EN_BIT = 0;
	localparam logic CTRL_EN_RESET = 1'b1;
	// ------------------------------------------------
	// Field codes
	// ------------------------------------------------
	localparam logic [3:0] EOP_NONE = 4'h0;
	localparam logic [3:0] EOP_ERR = 4'h1;
	localparam logic [3:0] HALF_WORDS = 4'h4;
	localparam logic [3:0] FULL_WORDS = 4'h8;
	localparam int UPPER_LSB = 4;
endpackage

/* logic/rx_user_if_block.sv */
// What this block does
// - Channel number of received traffic is driven on an 8-bit output.
// - Channel output is updated only with a start bit and non-zero count.
// - Valid-word count is 3 bits for four words, 10 bits otherwise.
// - With eight words, count bits [7:4] give valid words, zero to eight.
// - With eight words, count bits [3:0] are only four or zero.
// - Lower count field of four also raises packet-start bit 0.
// - Cycles without valid data drive both count fields to zero.
// - All eight words valid gives upper count field 1000.
// - Fewer words give 0 plus count; valid words packed from the top.
// - End-of-burst bit is driven in packet and interleaved modes.
// - End-of-packet code is 0000 when idle, 0001 for an errored end.
// - Clean end sets code top bit, low bits give final word bytes.
// - Codes 01xx and 001x are never emitted.
// - Final word valid bytes start at bits [63:56].
// - Start-of-burst is two bits, one bit for four words.
// - Burst start bit 1 aligns byte 63, bit 0 aligns byte 31.
// - Packet start bit 1 means byte 63, bit 0 means byte 31.
// - Errored-packet flag only meaningful while end-of-burst is high.
//
// Purpose: Registered receive user data output stage with APB control
// Assumes: Upstream symbol fields are synchronous to pclk
// Notes: CTRL enable gates traffic; two packet counters are readable
//
// The register addresses and the APB register port are this design's own decisions.
`timescale 1ns/1ps
module rx_user_if_block #(
	parameter int WORDS = rx_user_pkg::DEF_WORDS
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [rx_user_pkg::ADDR_BITS-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic in_valid,
	input wire logic [WORDS*rx_user_pkg::WORD_BITS-1:0] in_words,
	input wire logic [$clog2(WORDS+1)-1:0] in_count,
	input wire logic [rx_user_pkg::CHAN_BITS-1:0] in_chan,
	input wire logic [((WORDS==4)?1:2)-1:0] in_sop,
	input wire logic [((WORDS==4)?1:2)-1:0] in_sob,
	input wire logic in_eob,
	input wire logic in_eop,
	input wire logic in_err,
	input wire logic [2:0] in_bytes,
	output logic [rx_user_pkg::CHAN_BITS-1:0] rx_chan,
	output logic [((WORDS==4)?3:10)-1:0] rx_num_valid,
	output logic rx_eob,
	output logic [3:0] rx_eopbits,
	output logic [((WORDS==4)?1:2)-1:0] rx_sob,
	output logic [((WORDS==4)?1:2)-1:0] rx_sop,
	output logic rx_err,
	output logic [WORDS*rx_user_pkg::WORD_BITS-1:0] rx_dout_words
);
	localparam int NV = (WORDS == 4) ? 3 : 10;
	localparam int SW = (WORDS == 4) ? 1 : 2;
	localparam int CW = $clog2(WORDS + 1);
	localparam int DW = WORDS * rx_user_pkg::WORD_BITS;
	localparam int WB = rx_user_pkg::WORD_BITS;

	typedef struct packed {
		logic en;
		logic [31:0] pkts;
		logic [31:0] errs;
		logic [31:0] rdata;
		logic [rx_user_pkg::CHAN_BITS-1:0] chan;
		logic [NV-1:0] nv;
		logic eob;
		logic [3:0] eop;
		logic [SW-1:0] sob;
		logic [SW-1:0] sop;
		logic err;
		logic [DW-1:0] dat;
	} state_t;

	state_t s_reg;
	state_t s_next;
	logic v;
	logic low;
	logic [CW-1:0] cnt;
	logic wr;
	logic access;
	logic hit;

	// ------------------------------------------------
	// APB decode
	// ------------------------------------------------
	assign access = psel && penable;
	assign wr = access && pwrite;
	assign hit = (paddr == rx_user_pkg::CTRL_OFS) || (paddr == rx_user_pkg::PKT_CNT_OFS)
		|| (paddr == rx_user_pkg::ERR_CNT_OFS);
	assign pready = 1'b1;
	assign pslverr = access && !hit;
	assign prdata = s_reg.rdata;

	// ------------------------------------------------
	// Next state
	// ------------------------------------------------
	always_comb begin
		s_next = s_reg;
		v = in_valid && s_reg.en && (in_count != '0);
		cnt = (in_count > CW'(WORDS)) ? CW'(WORDS) : in_count;
		low = (WORDS == 8) && v && in_sop[0];
		// Count fields
		s_next.nv = '0;
		if (v) begin
			if (WORDS == 8) begin
				s_next.nv = NV'(NV'(cnt) << rx_user_pkg::UPPER_LSB);
				if (low) begin
					s_next.nv = s_next.nv | NV'(rx_user_pkg::HALF_WORDS);
				end
			end else begin
				s_next.nv = NV'(cnt);
			end
		end
		// Start and end markers
		s_next.sop = v ? in_sop : '0;
		if (low) begin
			s_next.sop[0] = 1'b1;
		end
		s_next.sob = v ? in_sob : '0;
		s_next.eob = v && in_eob;
		s_next.err = v && in_eob && in_err;
		if (v && ((|in_sop) || (|in_sob))) begin
			s_next.chan = in_chan;
		end
		s_next.eop = rx_user_pkg::EOP_NONE;
		if (v && in_eop) begin
			s_next.eop = in_err ? rx_user_pkg::EOP_ERR : {1'b1, in_bytes};
		end
		// Words packed from the top, unused low words zeroed
		for (int w = 0; w < WORDS; w++) begin
			if (v && ((w + int'(cnt)) >= WORDS)) begin
				s_next.dat[w*WB +: WB] = in_words[w*WB +: WB];
			end else begin
				s_next.dat[w*WB +: WB] = '0;
			end
		end
		// Counters; clear by write, new event wins
		if (wr && paddr == rx_user_pkg::PKT_CNT_OFS) begin
			s_next.pkts = '0;
		end
		if (wr && paddr == rx_user_pkg::ERR_CNT_OFS) begin
			s_next.errs = '0;
		end
		s_next.pkts = s_next.pkts + 32'(v && in_eop && !in_err);
		s_next.errs = s_next.errs + 32'(v && in_eop && in_err);
		if (wr && paddr == rx_user_pkg::CTRL_OFS) begin
			s_next.en = pwdata[rx_user_pkg::CTRL_EN_BIT];
		end
		// Read data captured in setup phase
		if (psel && !penable) begin
			case (paddr)
				rx_user_pkg::CTRL_OFS: s_next.rdata = {31'h0, s_reg.en};
				rx_user_pkg::PKT_CNT_OFS: s_next.rdata = s_reg.pkts;
				rx_user_pkg::ERR_CNT_OFS: s_next.rdata = s_reg.errs;
				default: s_next.rdata = 32'h0;
			endcase
		end
	end

	// ------------------------------------------------
	// State register
	// ------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.en <= rx_user_pkg::CTRL_EN_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign rx_chan = s_reg.chan;
	assign rx_num_valid = s_reg.nv;
	assign rx_eob = s_reg.eob;
	assign rx_eopbits = s_reg.eop;
	assign rx_sob = s_reg.sob;
	assign rx_sop = s_reg.sop;
	assign rx_err = s_reg.err;
	assign rx_dout_words = s_reg.dat;

	// ------------------------------------------------
	// Assertions
	// ------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence idle_in_s;
		!(in_valid && s_reg.en && in_count != '0);
	endsequence

	sequence valid_in_s;
		in_valid && s_reg.en && in_count != '0;
	endsequence

	sequence eop_in_s;
		valid_in_s ##0 in_eop;
	endsequence

	sequence start_in_s;
		valid_in_s ##0 ((|in_sop) || (|in_sob));
	endsequence

	sequence pkt_clear_s;
		psel && penable && pwrite && paddr == rx_user_pkg::PKT_CNT_OFS;
	endsequence

	// ------------------------------------------------
	// Count field checks
	// ------------------------------------------------
	zero_count_a: assert property (idle_in_s |=> rx_num_valid == '0 && rx_sop == '0)
		else $error("count not zero after idle cycle");

	low_field_a: assert property ((WORDS == 8) |-> (rx_num_valid[3:0] == 4'h0
		|| (rx_num_valid[3:0] == 4'h4 && rx_sop[0])))
		else $error("lower count field illegal");

	upper_range_a: assert property ((WORDS == 8) |-> rx_num_valid[7:4] <= 4'h8)
		else $error("upper count above eight");

	full_count_a: assert property ((WORDS == 8) && in_valid && s_reg.en && in_count == CW'(8)
		|=> rx_num_valid[7:4] == 4'h8)
		else $error("full symbol count wrong");

	upper_part_a: assert property ((WORDS == 8) ##0 valid_in_s ##0 (in_count < CW'(8))
		|=> rx_num_valid[7:4] == {1'b0, $past(in_count[2:0])})
		else $error("partial symbol count wrong");

	en_off_a: assert property (!s_reg.en |=> rx_num_valid == '0 && rx_eopbits == 4'h0)
		else $error("traffic passed while disabled");

	// ------------------------------------------------
	// Marker checks
	// ------------------------------------------------
	eop_legal_a: assert property (rx_eopbits[3:2] != 2'b01 && rx_eopbits[3:1] != 3'b001)
		else $error("undefined end code");

	err_code_a: assert property (eop_in_s ##0 in_err |=> rx_eopbits == 4'h1)
		else $error("errored end code wrong");

	eop_bytes_a: assert property (eop_in_s ##0 !in_err |=> rx_eopbits == {1'b1, $past(in_bytes)})
		else $error("end byte count wrong");

	idle_marks_a: assert property (idle_in_s |=> rx_sob == '0 && !rx_eob && !rx_err
		&& rx_eopbits == 4'h0)
		else $error("markers set after idle cycle");

	sop_pass_a: assert property (valid_in_s |=> rx_sop == $past(in_sop))
		else $error("packet start bits wrong");

	sob_pass_a: assert property (valid_in_s |=> rx_sob == $past(in_sob))
		else $error("burst start bits wrong");

	chan_hold_a: assert property (!(|rx_sop) && !(|rx_sob) |-> $stable(rx_chan) or
		$past(in_valid && s_reg.en && in_count != '0))
		else $error("channel moved without start");

	chan_load_a: assert property (start_in_s |=> rx_chan == $past(in_chan))
		else $error("channel not loaded at start");

	err_flag_a: assert property (rx_err |-> rx_eob)
		else $error("error flag without end of burst");

	err_pass_a: assert property (valid_in_s ##0 (in_eob && in_err) |=> rx_err)
		else $error("error flag lost");

	eob_pass_a: assert property (in_valid && s_reg.en && in_count != '0 && in_eob |=> rx_eob)
		else $error("end of burst lost");

	// ------------------------------------------------
	// Data word checks
	// ------------------------------------------------
	low_word_a: assert property ((WORDS == 8) && rx_num_valid[7:4] == 4'h7
		|-> rx_dout_words[WB-1:0] == '0)
		else $error("unused low word not zero");

	top_word_a: assert property (valid_in_s |=> rx_dout_words[DW-1 -: WB]
		== $past(in_words[DW-1 -: WB]))
		else $error("top word not carried");

	idle_word_a: assert property (idle_in_s |=> rx_dout_words == '0)
		else $error("data words not zero when idle");

	// ------------------------------------------------
	// Register checks
	// ------------------------------------------------
	apb_ready_a: assert property (pready)
		else $error("bus ready low");

	pkt_clear_a: assert property (pkt_clear_s ##0 !(in_valid && s_reg.en && in_count != '0
		&& in_eop && !in_err) |=> s_reg.pkts == 32'h0)
		else $error("packet counter not cleared");

	rdata_cap_a: assert property (psel && !penable && paddr == rx_user_pkg::ERR_CNT_OFS
		|=> prdata == $past(s_reg.errs))
		else $error("error count read wrong");

	slverr_a: assert property (psel && penable && paddr > rx_user_pkg::ERR_CNT_OFS |-> pslverr)
		else $error("unmapped access not flagged");

	en_write_a: assert property (psel && penable && pwrite && paddr == rx_user_pkg::CTRL_OFS
		|=> s_reg.en == $past(pwdata[rx_user_pkg::CTRL_EN_BIT]))
		else $error("enable write lost");
endmodule

/* dv/rx_consumer_model.sv */
// Purpose: Downstream consumer of received symbols
// Assumes: Eight-word layout
// Notes: Data words are never read
`timescale 1ns/1ps
module rx_consumer_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [7:0] rx_chan,
	input wire logic [9:0] rx_num_valid,
	input wire logic [1:0] rx_sop,
	input wire logic [1:0] rx_sob,
	input wire logic rx_eob,
	input wire logic rx_err,
	output logic [7:0] seen_chan,
	output logic [7:0] seen_err
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_chan <= 8'h00;
			seen_err <= 8'h00;
		end else begin
			if ((rx_sop != 2'b00 || rx_sob != 2'b00) && rx_num_valid != 10'h000) begin
				seen_chan <= rx_chan;
			end
			if (rx_eob && rx_err) begin
				seen_err <= seen_err + 8'h01;
			end
		end
	end
endmodule

/* dv/tb.sv */
// Purpose: Checks the receive user output stage
// Assumes: Eight words, APB control
// Notes: Expected fields worked out in sym
`timescale 1ns/1ps
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, in_valid, in_eob, in_eop;
	logic in_err, rx_eob, rx_err, en, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [511:0] in_words, rx_dout_words;
	logic [3:0] in_count, rx_eopbits;
	logic [7:0] in_chan, rx_chan, ec, seen_chan, seen_err;
	logic [1:0] in_sop, in_sob, rx_sop, rx_sob;
	logic [2:0] in_bytes;
	logic [9:0] rx_num_valid;
	int n_mismatch = 0;
	int tests_run = 0;
	int nclean = 0;
	int nerr = 0;
	rx_user_if_block #(.WORDS(8)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .in_valid, .in_words, .in_count, .in_chan,
		.in_sop, .in_sob, .in_eob, .in_eop, .in_err, .in_bytes, .rx_chan, .rx_num_valid,
		.rx_eob, .rx_eopbits, .rx_sob, .rx_sop, .rx_err, .rx_dout_words);
	rx_consumer_model consumer (.pclk, .presetn, .rx_chan, .rx_num_valid, .rx_sop,
		.rx_sob, .rx_eob, .rx_err, .seen_chan, .seen_err);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#40000;
		n_mismatch++;
		complete_run();
	end
	task automatic complete_run();
		if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic sym(input logic [22:0] f);
		logic v, eb, ep, er, on;
		logic [3:0] c;
		logic [1:0] sp, sb;
		logic [2:0] by;
		logic [7:0] ch;
		{v, c, sp, sb, eb, ep, er, by, ch} = f;
		on = v && en && c != 4'h0;
		@(posedge pclk);
		{in_valid, in_count, in_sop, in_sob, in_eob, in_eop, in_err, in_bytes, in_chan} <= f;
		@(posedge pclk);
		in_valid <= 1'b0;
		#1;
		if (on && (sp != 2'b00 || sb != 2'b00)) ec = ch;
		nclean += int'(on && ep && !er);
		nerr += int'(on && ep && er);
		chk("num", on ? {c, sp[0] ? 4'h4 : 4'h0} : 8'h00, rx_num_valid);
		chk("sop", on ? sp : 2'b00, rx_sop);
		chk("sob", on ? sb : 2'b00, rx_sob);
		chk("eob", on && eb, rx_eob);
		chk("err", on && eb && er, rx_err);
		chk("eop", !(on && ep) ? 4'h0 : er ? 4'h1 : {1'b1, by}, rx_eopbits);
		chk("chan", ec, rx_chan);
	endtask
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{in_valid, in_count, in_sop, in_sob, in_eob, in_eop, in_err, in_bytes, in_chan} = '0;
		in_words = {8{64'h0123456789ABCDEF}};
		en = 1'b1;
		ec = 8'h00;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		#1;
		chk("rst_num", 32'h0, rx_num_valid);
		apb(1'b0, rx_user_pkg::CTRL_OFS, 32'h0);
		chk("ctrl", 32'h1, rd);
		for (int i = 0; i < 8; i++) sym({9'h188, 3'b110, 3'(i), 8'(i)});
		sym({1'b1, 4'h7, 2'b00, 2'b10, 3'b000, 3'h0, 8'h5A});
		chk("word0", 32'h0, rx_dout_words[63:32]);
		chk("word1", 32'h01234567, rx_dout_words[127:96]);
		sym({1'b1, 4'h8, 2'b01, 2'b01, 3'b000, 3'h0, 8'hC3});
		sym({1'b1, 4'h4, 2'b00, 2'b00, 3'b111, 3'h5, 8'hFF});
		sym({1'b0, 4'h8, 2'b10, 2'b10, 3'b110, 3'h2, 8'h11});
		sym({1'b1, 4'h0, 2'b10, 2'b00, 3'b110, 3'h2, 8'h22});
		apb(1'b0, rx_user_pkg::PKT_CNT_OFS, 32'h0);
		chk("pkt_cnt", nclean, rd);
		apb(1'b0, rx_user_pkg::ERR_CNT_OFS, 32'h0);
		chk("err_cnt", nerr, rd);
		chk("model_err", nerr, seen_err);
		chk("model_chan", ec, seen_chan);
		apb(1'b1, rx_user_pkg::PKT_CNT_OFS, 32'h0);
		apb(1'b0, rx_user_pkg::PKT_CNT_OFS, 32'h0);
		chk("pkt_clr", 32'h0, rd);
		apb(1'b0, 12'h00C, 32'h0);
		chk("slverr", 32'h1, err);
		apb(1'b1, rx_user_pkg::CTRL_OFS, 32'h0);
		en = 1'b0;
		sym({1'b1, 4'h8, 2'b10, 2'b00, 3'b110, 3'h1, 8'h33});
		complete_run();
	end
endmodule
